/* rtl/mqw_device.sv */
// device end: queue select, data write, flag bus and expansion token
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`include "mqw_map.svh"

// Overview of operation
// - select strobe latches queue on clock edge
// - writer pulses select strobe once per pending select, writes while pending merge
// - writer never raises both strobes together
// - writer selects only after programming done low
// - write enable low stores input word
// - selection accepted regardless of write enable
// - new queue takes data two edges later
// - flag strobe picks device for flag bus
// - polled mode cycles flag bus with sync
// - flag outputs change only on write clock
// - expansion token driven and sampled on clock
// - writer keeps write clock running continuously
// - flag bus works without write enable
// - low bits queue, high bits device id
// - old queue written on select edge and next
// - flag select ignores low address bits
module mqw_device
  import mqw_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,

  // link to the writer
  mqw_link_if.dev          link,

  // strapping
  input  wire logic [2:0]  devId,
  input  wire logic        pollMode,

  // expansion chain
  input  wire logic        expansionTokenIn,
  output logic             expansionTokenOut,

  // read side toward user logic
  input  wire logic [1:0]  readQueue,
  input  wire logic        readStrobe,
  output logic      [17:0] readData,
  output logic             readValid,
  output logic      [3:0]  queueEmpty
);

  // state register and its next value
  mqw_dev_state_type st_ff;
  mqw_dev_state_type nxt_st;

  // queue steering and decode wires
  logic [3:0]        qPush;
  logic [3:0]        qPop;
  logic [3:0]        qFull;
  logic [3:0]        qAlmostFull;
  logic [17:0]       qPeek [0:3];
  logic              selMatch;
  logic              flagMatch;
  logic              doWrite;
  logic              progLast;
  logic              ownSlot;
  logic              slotZero;
  logic [2:0]        slotNext;
  logic              selAlmostFull;
  logic              selFull;
  logic              readHit;
  logic [1:0]        selQueue;
  logic [17:0]       headWord;

  // address decode: device bits against own id, queue bits apart
  assign selMatch  = (link.writeSelBus[`MQW_DEV_HI:`MQW_DEV_LO] == devId);
  assign flagMatch = (link.writeSelBus[`MQW_DEV_HI:`MQW_DEV_LO] == devId);

  // write into the queue held from before this edge
  assign doWrite = !link.writeEnN && st_ff.wrHit && !st_ff.progBusy
                   && !qFull[st_ff.wrQ];

  // queue field of the write bus, device bits compared above
  assign selQueue = link.writeSelBus[`MQW_QSEL_HI:`MQW_QSEL_LO];

  // last count of the programming phase
  assign progLast = (st_ff.progCnt == 5'h01);

  // polled slot compares and the free-running step
  assign ownSlot  = (st_ff.pollSlot == devId);
  assign slotZero = (st_ff.pollSlot == `MQW_SLOT_ZERO);
  assign slotNext = st_ff.pollSlot + 3'h1;

  // fill state of the queue now being written
  assign selAlmostFull = st_ff.wrHit && qAlmostFull[st_ff.wrQ];
  assign selFull       = st_ff.wrHit && qFull[st_ff.wrQ];

  // pop that finds a word waiting, and that word
  assign readHit  = readStrobe && !queueEmpty[readQueue];
  assign headWord = qPeek[readQueue];

  // one queue per address, push and pop steered by decode
  genvar gi;
  generate
    for (gi = 0; gi < `MQW_QCNT; gi = gi + 1)
    begin : g_queue
      assign qPush[gi] = doWrite && (st_ff.wrQ == 2'(gi));
      assign qPop[gi]  = readStrobe && (readQueue == 2'(gi));
      mqw_queue u_queue (
        .mclk       (mclk),
        .rst        (rst),
        .push       (qPush[gi]),
        .din        (link.dataIn),
        .pop        (qPop[gi]),
        .peek       (qPeek[gi]),
        .empty      (queueEmpty[gi]),
        .full       (qFull[gi]),
        .almostFull (qAlmostFull[gi])
      );
    end
  endgenerate

  // next state of the whole device
  always_comb
  begin
    nxt_st = st_ff;

    // programming phase after reset, done output falls when finished
    if (st_ff.progBusy)
    begin
      nxt_st.progCnt = st_ff.progCnt - 5'h01;
      if (progLast)
        nxt_st.progBusy = 1'b0;
    end

    // two-stage queue selection, stage one on the strobe edge
    nxt_st.pendValid = 1'b0;
    if (link.queueSelStrobe)
    begin
      nxt_st.pendValid = 1'b1;
      nxt_st.pendHit   = selMatch;
      nxt_st.pendQ     = selQueue;
    end
    // stage two: new queue in force from the second edge on
    if (st_ff.pendValid)
    begin
      nxt_st.wrHit = st_ff.pendHit;
      nxt_st.wrQ   = st_ff.pendQ;
    end

    // direct mode device pick for the flag bus
    if (link.flagDevStrobe)
      nxt_st.flagHit = flagMatch;

    // polled slot counter, token realigns the chain
    nxt_st.tokenIn  = expansionTokenIn;
    nxt_st.pollSlot = slotNext;
    if (st_ff.tokenIn)
      nxt_st.pollSlot = devId;
    nxt_st.tokenOut = pollMode && ownSlot;

    // flag bus contents and drive enable, all registered
    nxt_st.flagBus  = ~qAlmostFull;
    if (pollMode)
    begin
      nxt_st.flagOeN  = !ownSlot;
      nxt_st.flagSync = slotZero;
    end
    else
    begin
      nxt_st.flagOeN  = !st_ff.flagHit;
      nxt_st.flagSync = 1'b0;
    end

    // flags of the queue being written
    nxt_st.almostFullN = !selAlmostFull;
    nxt_st.fullN       = !selFull;

    // read side register
    nxt_st.readValid = readHit;
    if (readHit)
      nxt_st.readData = headWord;
  end

  // state register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_ff             <= '0;
      st_ff.progCnt     <= `MQW_PROG_CYCLES;
      st_ff.progBusy    <= 1'b1;
      st_ff.flagBus     <= 4'hf;
      st_ff.flagOeN     <= 1'b1;
      st_ff.almostFullN <= 1'b1;
      st_ff.fullN       <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // pins straight from the state register
  assign link.almostFullBusN     = st_ff.flagBus;
  assign link.almostFullBusOeN   = st_ff.flagOeN;
  assign link.almostFullN        = st_ff.almostFullN;
  assign link.fullFlagN          = st_ff.fullN;
  assign link.flagBusSync        = st_ff.flagSync;
  assign link.programmingDoneOut = st_ff.progBusy;
  assign expansionTokenOut       = st_ff.tokenOut;
  assign readData                = st_ff.readData;
  assign readValid               = st_ff.readValid;
endmodule

/* rtl/mqw_map.svh */
// constants of the multi-queue write port: widths, fields, timing, register map
`ifndef MQW_MAP_SVH
`define MQW_MAP_SVH
`define MQW_QCNT        4
`define MQW_DW          18
`define MQW_AW          5
`define MQW_Q_AW        13
`define MQW_Q_CW        14
`define MQW_Q_DEPTH     14'h2000
`define MQW_PAF_OFS     14'h0008
`define MQW_QSEL_HI     1
`define MQW_QSEL_LO     0
`define MQW_DEV_HI      4
`define MQW_DEV_LO      2
`define MQW_PROG_CYCLES 5'h10
`define MQW_SETTLE      2'h2
`define MQW_GAP         2'h1
`define MQW_SLOT_ZERO   3'h0
`define MQW_REG_SEL     4'h0
`define MQW_REG_FLAG    4'h1
`define MQW_REG_DATA    4'h2
`define MQW_REG_STAT    4'h3
`define MQW_REG_MASK    4'h4
`define MQW_REG_LIVE    4'h5
`define MQW_EV_SEL      0
`define MQW_EV_FLAG     1
`define MQW_EV_WRITTEN  2
`define MQW_EV_REFUSED  3
`define MQW_EV_PROG     4
`define MQW_EV_W        5
`define MQW_EV_NONE     5'h00
`define MQW_MASK_RST    5'h00
`endif

/* rtl/mqw_pkg.sv */
// types shared by both ends of the multi-queue write port
package mqw_pkg;
  typedef enum logic [1:0] {
    MQW_IDLE   = 2'b00,
    MQW_SETTLE = 2'b01
  } mqw_wstate_type;

  typedef struct packed {
    logic [12:0] wrPtr;
    logic [12:0] rdPtr;
    logic [13:0] count;
  } mqw_queue_state_type;

  typedef struct packed {
    logic [4:0]  progCnt;
    logic        progBusy;
    logic        pendValid;
    logic        pendHit;
    logic [1:0]  pendQ;
    logic        wrHit;
    logic [1:0]  wrQ;
    logic        flagHit;
    logic [2:0]  pollSlot;
    logic        tokenIn;
    logic        tokenOut;
    logic [3:0]  flagBus;
    logic        flagOeN;
    logic        flagSync;
    logic        almostFullN;
    logic        fullN;
    logic [17:0] readData;
    logic        readValid;
  } mqw_dev_state_type;

  typedef struct packed {
    mqw_wstate_type fsm;
    logic [1:0]  wait_cnt;
    logic        pendSel;
    logic [4:0]  selAddr;
    logic        pendFlag;
    logic [4:0]  flagAddr;
    logic        pendData;
    logic [17:0] dataWord;
    logic        selStrobe;
    logic        flagStrobe;
    logic [4:0]  selBus;
    logic        writeEnN;
    logic [17:0] dataOut;
    logic        progSeen;
    logic [4:0]  stat;
    logic [4:0]  mask;
    logic [31:0] rdData;
  } mqw_wr_state_type;
endpackage

/* rtl/mqw_link_if.sv */
// pins between the upstream writer and the multi-queue device
`timescale 1ns/1ps
interface mqw_link_if;
  logic        queueSelStrobe;
  logic        flagDevStrobe;
  logic [4:0]  writeSelBus;
  logic        writeEnN;
  logic [17:0] dataIn;
  logic [3:0]  almostFullBusN;
  logic        almostFullBusOeN;
  logic [3:0]  almostFullBusSeen;
  logic        almostFullN;
  logic        fullFlagN;
  logic        flagBusSync;
  logic        programmingDoneOut;

  // undriven shared flag bus floats high
  assign almostFullBusSeen = almostFullBusOeN ? 4'hf : almostFullBusN;

  modport dev (
    input  queueSelStrobe, flagDevStrobe, writeSelBus, writeEnN, dataIn,
    output almostFullBusN, almostFullBusOeN, almostFullN, fullFlagN,
    output flagBusSync, programmingDoneOut
  );
  modport wr (
    output queueSelStrobe, flagDevStrobe, writeSelBus, writeEnN, dataIn,
    input  almostFullBusSeen, almostFullN, fullFlagN, flagBusSync,
    input  programmingDoneOut
  );
endinterface

/* rtl/mqw_queue.sv */
// one queue: storage array with push, pop and fill flags
`timescale 1ns/1ps
`include "mqw_map.svh"
module mqw_queue
  import mqw_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // write side
  input  wire logic        push,
  input  wire logic [17:0] din,
  // read side
  input  wire logic        pop,
  output logic      [17:0] peek,
  // fill state
  output logic             empty,
  output logic             full,
  output logic             almostFull
);
  mqw_queue_state_type st_ff;
  mqw_queue_state_type nxt_st;
  logic [17:0]         mem [0:`MQW_Q_DEPTH-1];
  logic                doPush;
  logic                doPop;

  // refuse pushes when full, pops when empty
  assign doPush = push && !full;
  assign doPop  = pop && !empty;
  assign peek   = mem[st_ff.rdPtr];
  assign empty  = (st_ff.count == '0);
  assign full   = (st_ff.count == `MQW_Q_DEPTH);
  assign almostFull = (st_ff.count >= (`MQW_Q_DEPTH - `MQW_PAF_OFS));

  // pointer and count update
  always_comb
  begin
    nxt_st = st_ff;
    if (doPush)
      nxt_st.wrPtr = st_ff.wrPtr + 13'h0001;
    if (doPop)
      nxt_st.rdPtr = st_ff.rdPtr + 13'h0001;
    if (doPush && !doPop)
      nxt_st.count = st_ff.count + 14'h0001;
    else if (doPop && !doPush)
      nxt_st.count = st_ff.count - 14'h0001;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // storage write
  always_ff @(posedge mclk)
  begin
    if (doPush)
      mem[st_ff.wrPtr] <= din;
  end
endmodule

/* rtl/mqw_writer.sv */
// writer end: register port commands turned into select, flag and data cycles
`timescale 1ns/1ps
`include "mqw_map.svh"
module mqw_writer
  import mqw_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // link to the device
  mqw_link_if.wr           link,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  // interrupt
  output logic             irq
);
  mqw_wr_state_type st_ff;
  mqw_wr_state_type nxt_st;
  logic [4:0]       evSet;
  logic [4:0]       evClr;

  // register writes, events and the link sequencer
  always_comb
  begin
    nxt_st = st_ff;
    evSet  = `MQW_EV_NONE;
    evClr  = `MQW_EV_NONE;

    // strobes last one cycle only
    nxt_st.selStrobe  = 1'b0;
    nxt_st.flagStrobe = 1'b0;
    nxt_st.writeEnN   = 1'b1;

    if (regWr)
    begin
      unique case (regAddr)
        `MQW_REG_SEL:
        begin
          nxt_st.pendSel = 1'b1;
          nxt_st.selAddr = regWrData[4:0];
        end
        `MQW_REG_FLAG:
        begin
          nxt_st.pendFlag = 1'b1;
          nxt_st.flagAddr = regWrData[4:0];
        end
        `MQW_REG_DATA:
        begin
          nxt_st.pendData = 1'b1;
          nxt_st.dataWord = regWrData[17:0];
        end
        `MQW_REG_STAT: evClr = regWrData[4:0];
        `MQW_REG_MASK: nxt_st.mask = regWrData[4:0];
        default: ;
      endcase
    end

    // programming finished, selections now allowed
    if (!link.programmingDoneOut && !st_ff.progSeen)
    begin
      nxt_st.progSeen = 1'b1;
      evSet[`MQW_EV_PROG] = 1'b1;
    end

    unique case (st_ff.fsm)
      MQW_IDLE:
      begin
        if (!st_ff.progSeen)
          nxt_st.fsm = MQW_IDLE;
        else if (st_ff.pendSel)
        begin
          // one strobe per cycle, select before flag
          nxt_st.selStrobe = 1'b1;
          nxt_st.selBus    = st_ff.selAddr;
          nxt_st.pendSel   = regWr && (regAddr == `MQW_REG_SEL); // new select stays pending
          nxt_st.fsm       = MQW_SETTLE;
          nxt_st.wait_cnt  = `MQW_SETTLE;
          evSet[`MQW_EV_SEL] = 1'b1;
        end
        else if (st_ff.pendFlag)
        begin
          nxt_st.flagStrobe = 1'b1;
          nxt_st.selBus     = st_ff.flagAddr;
          nxt_st.pendFlag   = regWr && (regAddr == `MQW_REG_FLAG); // new pick stays pending
          evSet[`MQW_EV_FLAG] = 1'b1;
        end
        else if (st_ff.pendData)
        begin
          nxt_st.pendData = regWr && (regAddr == `MQW_REG_DATA); // new word stays pending
          if (link.fullFlagN)
          begin
            nxt_st.writeEnN = 1'b0;
            nxt_st.dataOut  = st_ff.dataWord;
            nxt_st.fsm      = MQW_SETTLE;
            nxt_st.wait_cnt = `MQW_GAP;
            evSet[`MQW_EV_WRITTEN] = 1'b1;
          end
          else
            evSet[`MQW_EV_REFUSED] = 1'b1;
        end
      end
      MQW_SETTLE:
      begin
        if (st_ff.wait_cnt == 2'h0)
          nxt_st.fsm = MQW_IDLE;
        else
          nxt_st.wait_cnt = st_ff.wait_cnt - 2'h1;
      end
      default: nxt_st.fsm = MQW_IDLE;
    endcase

    // sticky status, a new event beats the clear
    nxt_st.stat = (st_ff.stat & ~evClr) | evSet;

    // read data one cycle after the strobe
    nxt_st.rdData = '0;
    if (regRd)
    begin
      unique case (regAddr)
        `MQW_REG_STAT: nxt_st.rdData = {27'h0, st_ff.stat};
        `MQW_REG_MASK: nxt_st.rdData = {27'h0, st_ff.mask};
        `MQW_REG_LIVE: nxt_st.rdData = {23'h0, link.programmingDoneOut,
                                        link.almostFullBusSeen, link.almostFullN,
                                        link.fullFlagN, link.flagBusSync,
                                        (st_ff.fsm != MQW_IDLE)};
        default: nxt_st.rdData = '0;
      endcase
    end
  end

  // state register on the free-running clock
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_ff          <= '0;
      st_ff.writeEnN <= 1'b1;
      st_ff.mask     <= `MQW_MASK_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // pins and port outputs from the state register
  assign link.queueSelStrobe = st_ff.selStrobe;
  assign link.flagDevStrobe  = st_ff.flagStrobe;
  assign link.writeSelBus    = st_ff.selBus;
  assign link.writeEnN       = st_ff.writeEnN;
  assign link.dataIn         = st_ff.dataOut;
  assign regRdData           = st_ff.rdData;
  assign irq                 = |(st_ff.stat & st_ff.mask);
endmodule

/* testbench/mqw_link_sva.sv */
// link checker: timing relations between writer and device pins
`timescale 1ns/1ps
module mqw_link_sva
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // link pins
  input wire logic       queueSelStrobe,
  input wire logic       flagDevStrobe,
  input wire logic [4:0] writeSelBus,
  input wire logic       writeEnN,
  input wire logic       almostFullBusOeN,
  input wire logic       flagBusSync,
  input wire logic       programmingDoneOut,
  // device straps
  input wire logic [2:0] devId,
  input wire logic       pollMode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // strobes and programming
  strobe_overlap_a: assert property (!(queueSelStrobe && flagDevStrobe))
    else $error("select and flag strobes together");
  sel_after_prog_a: assert property (queueSelStrobe |-> !programmingDoneOut)
    else $error("select strobe while programming");
  sel_pulse_a: assert property (queueSelStrobe |=> !queueSelStrobe)
    else $error("select strobe held high");
  sel_spacing_a: assert property (queueSelStrobe |=> writeEnN [*2])
    else $error("word too soon after select");
  prog_hold_a: assert property ($fell(rst) |-> programmingDoneOut [*8])
    else $error("programming ended too early");

  // flag bus in direct and polled mode
  flag_pick_a: assert property (!pollMode && flagDevStrobe && writeSelBus[4:2] == devId
    |-> ##[1:2] !almostFullBusOeN)
    else $error("own device not put on flag bus");
  flag_drop_a: assert property (!pollMode && flagDevStrobe && writeSelBus[4:2] != devId
    |-> ##[1:2] almostFullBusOeN)
    else $error("flag bus kept for other device");
  sync_period_a: assert property (disable iff (rst || !pollMode)
    flagBusSync |=> !flagBusSync [*7] ##1 flagBusSync)
    else $error("sync pulse period wrong");
  own_slot_a: assert property (pollMode && $past(pollMode, 2) && !almostFullBusOeN
    |=> almostFullBusOeN)
    else $error("flag bus driven beyond own slot");
  direct_nosync_a: assert property (!pollMode && !$past(pollMode) |-> !flagBusSync)
    else $error("sync pulse in direct mode");
endmodule

/* testbench/test_multi_queue_write_port_control.sv */
// bench: writer and device joined over the link, driven through registers
`timescale 1ns/1ps
`include "mqw_map.svh"
module test_multi_queue_write_port_control;
  localparam logic [2:0] OWN_ID = 3'h5;
  logic        mclk;
  logic        rst;
  logic [3:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdData;
  logic        irq;
  logic        pollMode;
  logic        tokenIn;
  logic        tokenOut;
  logic [1:0]  readQueue;
  logic        readStrobe;
  logic [17:0] readData;
  logic        readValid;
  logic [3:0]  queueEmpty;
  logic [31:0] v;
  int          miscompares;
  int          tests_run;
  int          cycles;

  mqw_link_if link ();
  mqw_writer mqw_writer_i (.mclk(mclk), .rst(rst), .link(link), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq));
  mqw_device mqw_device_i (.mclk(mclk), .rst(rst), .link(link), .devId(OWN_ID),
    .pollMode(pollMode), .expansionTokenIn(tokenIn), .expansionTokenOut(tokenOut),
    .readQueue(readQueue), .readStrobe(readStrobe), .readData(readData),
    .readValid(readValid), .queueEmpty(queueEmpty));
  mqw_link_sva mqw_link_sva_i (.mclk(mclk), .rst(rst), .queueSelStrobe(link.queueSelStrobe),
    .flagDevStrobe(link.flagDevStrobe), .writeSelBus(link.writeSelBus),
    .writeEnN(link.writeEnN), .almostFullBusOeN(link.almostFullBusOeN),
    .flagBusSync(link.flagBusSync), .programmingDoneOut(link.programmingDoneOut),
    .devId(OWN_ID), .pollMode(pollMode));

  // clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // register port cycles
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [3:0] a);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    v = regRdData;
    @(posedge mclk);
  endtask

  // one word, then the writer's spacing
  task automatic put(input logic [17:0] d);
    wr(`MQW_REG_DATA, {14'h0, d});
    repeat (4) @(posedge mclk);
  endtask

  task automatic pop(input logic [1:0] q, input logic [17:0] exp);
    int n;
    readQueue  <= q;
    readStrobe <= 1'b1;
    @(posedge mclk);
    readStrobe <= 1'b0;
    n = 0;
    #1;
    while (readValid !== 1'b1 && n < 4)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("read word", {14'h0, readData}, {14'h0, exp});
    @(posedge mclk);
  endtask

  task automatic s_reset();
    int n;
    rd(`MQW_REG_MASK);
    chk("mask reset", v, 32'h0);
    n = 0;
    rd(`MQW_REG_LIVE);
    while (v[8] !== 1'b0 && n < 40)
    begin
      rd(`MQW_REG_LIVE);
      n++;
    end
    chk("prog done", {31'h0, v[8]}, 32'h0);
    rd(4'hf);
    chk("unmapped read", v, 32'h0);
  endtask

  task automatic s_queues();
    for (int q = 0; q < 4; q++)
    begin
      wr(`MQW_REG_SEL, {27'h0, OWN_ID, q[1:0]});
      repeat (4) @(posedge mclk);
      put(18'h2a5a0 + 18'(q));
    end
    #1;
    chk("queues filled", {28'h0, queueEmpty}, 32'h0);
    for (int q = 0; q < 4; q++)
      pop(q[1:0], 18'h2a5a0 + 18'(q));
    rd(`MQW_REG_STAT);
    chk("status events", v, 32'h15);
    // other device id: words must go nowhere
    wr(`MQW_REG_SEL, {27'h0, OWN_ID + 3'h1, 2'h2});
    repeat (4) @(posedge mclk);
    put(18'h00777);
    #1;
    chk("foreign words", {28'h0, queueEmpty}, 32'hf);
    wr(`MQW_REG_SEL, {27'h0, OWN_ID, 2'h0});
    repeat (4) @(posedge mclk);
  endtask

  task automatic s_irq();
    wr(`MQW_REG_STAT, 32'h1f);
    wr(`MQW_REG_MASK, 32'h04);
    chk("irq idle", {31'h0, irq}, 32'h0);
    put(18'h3ffff);
    chk("irq raised", {31'h0, irq}, 32'h1);
    wr(`MQW_REG_STAT, 32'h04);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(`MQW_REG_MASK, 32'h0);
    put(18'h00001);
    chk("irq masked", {31'h0, irq}, 32'h0);
    pop(2'h0, 18'h3ffff);
    pop(2'h0, 18'h00001);
  endtask

  task automatic s_fill();
    wr(`MQW_REG_FLAG, {27'h0, OWN_ID, 2'h3});
    for (int i = 0; i < 8192; i++)
      put(18'(i));
    rd(`MQW_REG_LIVE);
    chk("full flags", v & 32'h1fc, 32'h0e0);
    wr(`MQW_REG_STAT, 32'h1f);
    put(18'h12345);
    rd(`MQW_REG_STAT);
    chk("refused word", v & 32'h0c, 32'h08);
    wr(`MQW_REG_FLAG, {27'h0, OWN_ID + 3'h2, 2'h1});
    repeat (3) @(posedge mclk);
    rd(`MQW_REG_LIVE);
    chk("flag bus freed", v & 32'hf0, 32'hf0);
    pop(2'h0, 18'h0);
  endtask

  task automatic s_poll();
    int syncs;
    int slots;
    int n;
    syncs = 0;
    slots = 0;
    pollMode <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 32; i++)
    begin
      @(posedge mclk);
      #1;
      syncs += int'(link.flagBusSync === 1'b1);
      slots += int'(tokenOut === 1'b1);
    end
    chk("sync pulses", syncs, 4);
    chk("token slots", slots, 4);
    // token from the chain reloads the slot: own slot three edges on
    n = 0;
    while (tokenOut !== 1'b1 && n < 16)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    tokenIn <= 1'b1;
    @(posedge mclk);
    tokenIn <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("token reload", {31'h0, tokenOut}, 32'h1);
    // leave poll mode before the stretched sync gap ends
    pollMode <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // main sequence
  initial
  begin
    mclk       = 1'b0;
    rst        = 1'b1;
    regAddr    = 4'h0;
    regWrData  = 32'h0;
    regWr      = 1'b0;
    regRd      = 1'b0;
    pollMode   = 1'b0;
    tokenIn    = 1'b0;
    readQueue  = 2'h0;
    readStrobe = 1'b0;
    miscompares = 0;
    tests_run   = 0;
    cycles      = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    s_reset();
    s_queues();
    s_irq();
    s_fill();
    s_poll();
    close_out();
  end
endmodule
